// file: pucs_env_model.sv
/* far-side model: supply, thermal and open-circuit indications plus the upper neighbour's
   shutdown input. assumes bench knobs change on the falling edge. */
`timescale 1ns/1ps
module pucs_env_model import pucs_pkg::*; (
    // clock and knobs {good, stack, droop, hot, cooled, open, delay}
    input wire logic core_clk,
    input wire logic [6:0] knob,
    // sequencer side
    input wire pucs_ctrl_t ctrl,
    output pucs_analog_t analog_in,
    output logic upper_pd_n
);
    logic [3:0] chg_r = 4'h0;
    // pump charges the neighbour input; standby keeps the charge
    always @(posedge core_clk) begin
        if (!ctrl.regulator_en) begin
            chg_r <= 4'h0;
        end else if (ctrl.pump_en && chg_r != 4'hf) begin
            chg_r <= chg_r + 4'h1;
        end
    end
    assign upper_pd_n = chg_r[3];
    // a droop knocks the upper rail out of regulation
    assign analog_in = {knob[6:5], chg_r[3] & ~knob[4], knob[4:0]};
endmodule

// file: pucs_pkg.sv
/*
 * package for the power-up configuration sequencer: timing counts, threshold
 * decode constants, state enumeration and grouped port structs.
 * assumes a 40 MHz core clock; analog comparators live outside.
 */
package pucs_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int POR_DELAY_US = 1000;
    localparam int PUMP_SETTLE_US = 3000;
    localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
    localparam int PUMP_SETTLE_CYC = PUMP_SETTLE_US * CLK_MHZ;
    localparam int SELFTEST_CYC = 4;
    // ----------------------------------------------------------------
    // threshold decode, millivolts
    // ----------------------------------------------------------------
    localparam logic [12:0] OV_BASE_MV = 13'd3300;
    localparam logic [12:0] OV_STEP_MV = 13'd100;
    localparam logic [12:0] UV_BASE_MV = 13'd1600;
    localparam logic [12:0] UV_STEP_MV = 13'd200;
    localparam logic [3:0] OV_CODE_RST = 4'h0;
    localparam logic [2:0] UV_CODE_RST = 3'h0;
    localparam int NCELL = 12;

    typedef enum logic [2:0] {
        ST_OFF, ST_POR_WAIT, ST_PUMP_WAIT, ST_TOP_CHECK, ST_SELFTEST,
        ST_CELL_DET, ST_READY
    } pucs_state_t;

    // analog-side indications into the sequencer
    typedef struct packed {
        logic supply_good;      // regulated supply above por threshold
        logic stack_ok;         // stack supply sufficient
        logic upper_reg;        // upper port supply in regulation
        logic upper_droop;      // upper port supply fell ~35mV
        logic hot_trip;         // die over-temperature
        logic cooled;           // cooled 15 degrees below trip
        logic open_supply;      // supply-pin open-circuit comparator
        logic delay_expired;    // fault delay capacitor reached threshold
    } pucs_analog_t;

    typedef struct packed {
        logic regulator_en;
        logic core_reset_n;
        logic osc_en;
        logic pump_en;
        logic ready;
        logic selftest_mode;
        logic fault;
    } pucs_ctrl_t;
endpackage

// file: pucs_sequencer.sv
/*
 * power-up configuration sequencer: threshold code capture, reset release,
 * pump control, top check, comparator self-test, cell detection, thermal
 * shutdown and supply-open fault.
 * assumes all inputs synchronous to core_clk; rstn is the power-on reset.
 */
`timescale 1ns/1ps

// Contract
// - ov code: 3.3V plus 100mV per step
// - uv code zero disables, else 1.6V+200mV steps
// - threshold codes latched once per power-up
// - logic held reset while supply low
// - 1ms later release reset, oscillator, pump
// - 3ms settle, top check, selftest, cells, ready
// - pump standby in regulation, resume on droop
// - over-temperature shuts down until cooled 15 degrees
// - sustained supply-open after power-up raises alarm
// - regulator on only when enabled and supplied
// - power-down inactive powers up, active shuts down
// - pump drives next module's power-down input high
// - power-down removes drive to upper module
// - selftest failure alarms until power cycle
// - low cells lose undervoltage check only
// - top select sampled continuously
module pucs_sequencer import pucs_pkg::*; #(
    // settle counts; defaults are the real delays, a bench may shorten them
    parameter int POR_CYC = POR_DELAY_CYC,
    parameter int SETTLE_CYC = PUMP_SETTLE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // pins
    input wire logic power_down_request_n,
    input wire logic [3:0] over_threshold_code,
    input wire logic [2:0] under_threshold_code,
    input wire logic top_device_select,
    // analog indications
    input wire pucs_analog_t analog_in,
    input wire logic [NCELL-1:0] cell_present,
    input wire logic [NCELL-1:0] ov_selftest_hit,
    // outputs
    output pucs_ctrl_t ctrl,
    output logic [12:0] ov_threshold_mv,
    output logic [12:0] uv_threshold_mv,
    output logic uv_enabled,
    output logic [NCELL-1:0] uv_cell_en,
    output logic is_top,
    output logic lower_alarm_output
);
    typedef struct packed {
        pucs_state_t st;
        logic [17:0] cnt;
        logic [3:0] ov_code;
        logic [2:0] uv_code;
        logic hot;
        logic st_fail;
        logic open_fault;
        logic pump_standby;
        logic [NCELL-1:0] uv_cell;
        logic top;
        pucs_ctrl_t ctrl;
        logic [12:0] ov_mv;
        logic [12:0] uv_mv;
        logic uv_en;
        logic alarm;
    } pucs_reg_t;

    pucs_reg_t s_r;
    pucs_reg_t s_nxt;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [12:0] ov_mv_of(input logic [3:0] c);
        ov_mv_of = OV_BASE_MV + OV_STEP_MV * {9'h000, c};
    endfunction

    function automatic logic [12:0] uv_mv_of(input logic [2:0] c);
        // code zero returns zero, meaning undervoltage is off
        if (c == 3'h0) begin
            uv_mv_of = 13'h0000;
        end else begin
            uv_mv_of = UV_BASE_MV + UV_STEP_MV * {10'h000, c - 3'h1};
        end
    endfunction

    logic pwr_ok;
    assign pwr_ok = power_down_request_n && analog_in.stack_ok;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.top = top_device_select; // continuous, never latched
        // thermal latch: trip sets, only a full cooldown clears
        if (analog_in.hot_trip) begin
            s_nxt.hot = 1'b1;
        end else if (analog_in.cooled) begin
            s_nxt.hot = 1'b0;
        end
        s_nxt.ctrl.regulator_en = pwr_ok && !s_nxt.hot;
        if (!pwr_ok || s_nxt.hot || !analog_in.supply_good) begin
            // shutdown drops pump drive; upper modules follow only when regulator_en drops too, not on supply_good low alone
            s_nxt.st = ST_OFF;
            s_nxt.cnt = 18'h00000;
            s_nxt.ctrl.core_reset_n = 1'b0;
            s_nxt.ctrl.osc_en = 1'b0;
            s_nxt.ctrl.pump_en = 1'b0;
            s_nxt.ctrl.ready = 1'b0;
            s_nxt.ctrl.selftest_mode = 1'b0;
            s_nxt.pump_standby = 1'b0;
            s_nxt.open_fault = 1'b0;
        end else begin
            s_nxt.cnt = s_r.cnt + 18'h00001;
            unique case (s_r.st)
                ST_OFF: begin
                    // codes captured once at the start of each power-up
                    s_nxt.ov_code = over_threshold_code;
                    s_nxt.uv_code = under_threshold_code;
                    s_nxt.st_fail = 1'b0;
                    s_nxt.st = ST_POR_WAIT;
                    s_nxt.cnt = 18'h00000;
                end
                ST_POR_WAIT: begin
                    if (s_r.cnt == 18'(POR_CYC - 1)) begin
                        s_nxt.ctrl.core_reset_n = 1'b1;
                        s_nxt.ctrl.osc_en = 1'b1;
                        s_nxt.ctrl.pump_en = 1'b1; // raises upper input
                        s_nxt.st = ST_PUMP_WAIT;
                        s_nxt.cnt = 18'h00000;
                    end
                end
                ST_PUMP_WAIT: begin
                    if (s_r.cnt == 18'(SETTLE_CYC - 1)) begin
                        s_nxt.st = ST_TOP_CHECK;
                        s_nxt.cnt = 18'h00000;
                    end
                end
                ST_TOP_CHECK: begin
                    s_nxt.st = ST_SELFTEST; // top flag already live
                    s_nxt.ctrl.selftest_mode = 1'b1;
                    s_nxt.cnt = 18'h00000;
                end
                ST_SELFTEST: begin
                    // ground reference forces every comparator to trip
                    if (s_r.cnt == 18'(SELFTEST_CYC - 1)) begin
                        s_nxt.st_fail = ~&ov_selftest_hit;
                        s_nxt.ctrl.selftest_mode = 1'b0;
                        s_nxt.st = ST_CELL_DET;
                    end
                end
                ST_CELL_DET: begin
                    // ov stays on for every cell; only uv is gated
                    s_nxt.uv_cell = cell_present;
                    s_nxt.st = ST_READY;
                    s_nxt.ctrl.ready = 1'b1;
                end
                ST_READY: begin
                    s_nxt.cnt = s_r.cnt;
                    // open-circuit needs the full fault delay to latch
                    if (analog_in.open_supply && analog_in.delay_expired) begin
                        s_nxt.open_fault = 1'b1;
                    end
                end
            endcase
            // pump standby only once running
            if (s_nxt.ctrl.osc_en) begin
                if (analog_in.upper_droop) begin
                    s_nxt.pump_standby = 1'b0;
                end else if (analog_in.upper_reg) begin
                    s_nxt.pump_standby = 1'b1;
                end
                s_nxt.ctrl.pump_en = !s_nxt.pump_standby;
            end
        end
        s_nxt.ov_mv = ov_mv_of(s_nxt.ov_code);
        s_nxt.uv_mv = uv_mv_of(s_nxt.uv_code);
        s_nxt.uv_en = (s_nxt.uv_code != 3'h0);
        // self-test fault persists until reset or power cycle
        s_nxt.ctrl.fault = s_nxt.st_fail || s_nxt.open_fault;
        s_nxt.alarm = s_nxt.ctrl.fault;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{st: ST_OFF, cnt: 18'h00000, ov_code: OV_CODE_RST,
                     uv_code: UV_CODE_RST, ov_mv: OV_BASE_MV,
                     default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ctrl = s_r.ctrl;
    assign ov_threshold_mv = s_r.ov_mv;
    assign uv_threshold_mv = s_r.uv_mv;
    assign uv_enabled = s_r.uv_en;
    assign uv_cell_en = s_r.uv_cell;
    assign is_top = s_r.top;
    assign lower_alarm_output = s_r.alarm;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    ov_decode_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ov_threshold_mv == OV_BASE_MV + OV_STEP_MV * {9'h000, s_r.ov_code})
        else $error("ov threshold decode wrong");
    uv_decode_a: assert property (@(posedge core_clk) disable iff (!rstn)
        uv_enabled == (s_r.uv_code != 3'h0))
        else $error("uv enable decode wrong");
    code_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_r.st != ST_OFF |=> $stable(s_r.ov_code) || $past(s_r.st) == ST_OFF)
        else $error("threshold code changed after capture");
    reset_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !analog_in.supply_good |=> !ctrl.core_reset_n && !ctrl.ready)
        else $error("reset not held on low supply");
    por_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_r.st == ST_POR_WAIT && $past(s_r.st) == ST_OFF |-> !ctrl.osc_en)
        else $error("oscillator started early");
    ready_order_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(ctrl.ready) |-> $past(s_r.st) == ST_CELL_DET)
        else $error("ready before cell detection");
    thermal_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        analog_in.hot_trip |=> !ctrl.regulator_en)
        else $error("regulator on while hot");
    power_down_request_n_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !power_down_request_n |=> !ctrl.regulator_en && !ctrl.pump_en)
        else $error("still powered in shutdown");
    st_fault_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_r.st_fail |-> lower_alarm_output)
        else $error("selftest fault not alarmed");
    top_live_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(rstn) |-> is_top == $past(top_device_select))
        else $error("top select not tracked");
endmodule

// file: pucs_sequencer_test.sv
/* testbench for the sequencer: notes expected outputs in a queue and a
   watcher compares them. assumes the settle counts are shortened through
   the sequencer's parameters so that two full power-ups stay brief. */
`timescale 1ns/1ps
module pucs_sequencer_test import pucs_pkg::*; ;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    typedef struct packed {logic [48:0] m; logic [48:0] v;} pucs_note_t;
    localparam int UPN = 48, REG = 47, RST = 46, OSC = 45, PMP = 44;
    localparam int RDY = 43, STM = 42, FLT = 41;
    // short settle counts keep each full power-up brief
    localparam int POR_T = 400, SET_T = 1200;
    logic core_clk = 1'b0, rstn = 1'b0, pd_n = 1'b0, top_sel = 1'b0;
    logic [3:0] ovc = 4'h0;
    logic [2:0] uvc = 3'h0;
    logic [6:0] knob = 7'h60;
    logic [11:0] cells = 12'hfff, hits = 12'hfff, uvce;
    logic [12:0] ovt, uvt;
    logic uve, top, alarm, upn;
    logic [31:0] lfsr = 32'h1383;
    pucs_analog_t ana;
    pucs_ctrl_t ctrl;
    pucs_note_t note_q[$], cur;
    event note_ev;
    int err_total = 0, total_checks = 0;
    wire [48:0] obs = {upn, ctrl, ovt, uvt, uve, uvce, top, alarm};

    pucs_sequencer #(.POR_CYC(POR_T), .SETTLE_CYC(SET_T)) u_pucs_sequencer (
        .core_clk(core_clk), .rstn(rstn),
        .power_down_request_n(pd_n), .over_threshold_code(ovc),
        .under_threshold_code(uvc), .top_device_select(top_sel),
        .analog_in(ana), .cell_present(cells), .ov_selftest_hit(hits),
        .ctrl(ctrl), .ov_threshold_mv(ovt), .uv_threshold_mv(uvt),
        .uv_enabled(uve), .uv_cell_en(uvce), .is_top(top),
        .lower_alarm_output(alarm));
    pucs_env_model u_pucs_env_model (.core_clk(core_clk), .knob(knob),
        .ctrl(ctrl), .analog_in(ana), .upper_pd_n(upn));

    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [48:0] at(int lsb, logic [12:0] v);
        return 49'(v) << lsb;
    endfunction
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic step(int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(logic [48:0] m, logic [48:0] v);
        note_q.push_back(pucs_note_t'{m, v});
        -> note_ev;
    endtask
    // bounded wait, never a free-running hang
    task automatic wait_bit(int b, int lim);
        int k;
        k = 0;
        while (obs[b] !== 1'b1 && k < lim) begin
            step(1);
            k++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watcher takes the oldest note and compares the masked outputs
    always @(note_ev) begin
        while (note_q.size() > 0) begin
            cur = note_q.pop_front();
            total_checks++;
            if ((obs & cur.m) !== cur.v) begin
                err_total++;
                $display("wrong value at %0t: got %h want %h", $time,
                    obs & cur.m, cur.v);
            end
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // two full power-ups dominate the run length
    initial begin
        step(2 * (POR_T + SET_T) + 1000);
        err_total++;
        test_done();
    end

    initial begin
        int u;
        logic [12:0] uvx;
        step(16);
        rstn = 1'b1;
        step(2);
        chk(~49'h0, at(28, OV_BASE_MV));
        knob = 7'h20;
        pd_n = 1'b1;
        step(6);
        chk(at(REG, 1) | at(RST, 1), at(REG, 1));
        knob = 7'h40;
        step(6);
        chk(at(REG, 1), 49'h0);
        knob = 7'h68;
        step(6);
        chk(at(REG, 1), 49'h0);
        pd_n = 1'b0;
        knob = 7'h64;
        step(6);
        chk(at(REG, 1), 49'h0);
        // every code, then a random disturbance after capture
        for (int i = 0; i < 16; i++) begin
            ovc = i[3:0];
            uvc = i[2:0];
            pd_n = 1'b1;
            step(3);
            lfsr = nxt(lfsr);
            ovc = lfsr[3:0];
            uvc = lfsr[6:4];
            step(3);
            u = i % 8;
            uvx = (u == 0) ? 13'h0 : UV_BASE_MV + UV_STEP_MV * 13'(u - 1);
            chk(at(28, 13'h1fff) | at(15, 13'h1fff) | at(14, 1) | at(REG, 1),
                at(28, OV_BASE_MV + OV_STEP_MV * 13'(i)) | at(15, uvx) |
                at(14, 13'(u != 0)) | at(REG, 1));
            pd_n = 1'b0;
            step(4);
        end
        // full power-up: good self-test, then one comparator missing
        for (int p = 0; p < 2; p++) begin
            lfsr = nxt(lfsr);
            cells = lfsr[11:0] | 12'h001;
            hits = (p == 1) ? ~(12'h1 << lfsr[2:0]) : 12'hfff;
            top_sel = 1'b1;
            pd_n = 1'b1;
            step(POR_T - 5);
            chk(at(RST, 1) | at(OSC, 1) | at(PMP, 1), 49'h0);
            wait_bit(OSC, 10);
            chk(at(RST, 1) | at(OSC, 1) | at(PMP, 1),
                at(RST, 1) | at(OSC, 1) | at(PMP, 1));
            step(SET_T - 10);
            chk(at(RDY, 1), 49'h0);
            wait_bit(STM, 20);
            chk(at(STM, 1) | at(RDY, 1), at(STM, 1));
            wait_bit(RDY, 20);
            chk(at(RDY, 1) | at(FLT, 1) | at(PMP, 1) | at(UPN, 1) |
                at(STM, 1) | at(2, 13'h0fff) | at(1, 1) | at(0, 1),
                at(RDY, 1) | at(FLT, 13'(p)) | at(UPN, 1) | at(2, 13'(cells)) |
                at(1, 1) | at(0, 13'(p)));
            if (p == 0) begin
                knob = 7'h70;
                step(3);
                chk(at(PMP, 1) | at(UPN, 1), at(PMP, 1) | at(UPN, 1));
                top_sel = 1'b0;
                knob = 7'h62;
                step(6);
                chk(at(1, 1) | at(0, 1), 49'h0);
                knob = 7'h63;
                step(3);
                chk(at(0, 1) | at(RDY, 1), at(0, 1) | at(RDY, 1));
                knob = 7'h60;
                step(3);
                chk(at(0, 1), at(0, 1));
            end else begin
                knob = 7'h68;
                step(3);
                chk(at(REG, 1) | at(RDY, 1), 49'h0);
                knob = 7'h60;
                step(5);
                chk(at(REG, 1), 49'h0);
                knob = 7'h64;
                step(3);
                chk(at(REG, 1), at(REG, 1));
            end
            pd_n = 1'b0;
            step(3);
            chk(at(REG, 1) | at(RDY, 1) | at(UPN, 1), 49'h0);
            knob = 7'h60;
            step(2);
        end
        test_done();
    end
endmodule
